// ==== hw/fac_pkg.sv ====
// Package: register map, field layout and constants of the alarm codeword controller
package fac_pkg;

   // ------------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------------
   localparam logic [7:0] FAC_ADDR_CTRL     = 8'h60;
   localparam logic [7:0] FAC_ADDR_LIVE     = 8'h61;
   localparam logic [7:0] FAC_ADDR_STICKY   = 8'h62;
   localparam logic [7:0] FAC_ADDR_IRQ_EN   = 8'h63;
   localparam logic [7:0] FAC_ADDR_TX_FIRST = 8'h64;
   localparam logic [7:0] FAC_ADDR_TX_SEC   = 8'h65;
   localparam logic [7:0] FAC_ADDR_RX_DATA  = 8'h66;

   // ------------------------------------------------------------------
   // Field positions and reset values
   // ------------------------------------------------------------------
   localparam int FAC_CTRL_RX_RESET_BIT = 2;
   localparam int FAC_ST_TX_IDLE        = 0;
   localparam int FAC_ST_RX_SEEN        = 1;
   localparam int FAC_ST_RX_IDLE        = 2;
   localparam int FAC_ST_RX_NONEMPTY    = 3;
   localparam int FAC_ST_RX_OVERFLOW    = 4;
   localparam logic [7:0] FAC_RST_REG   = 8'h00;
   localparam logic [3:0] FAC_LIVE_RST  = 4'h9;   // Queue empty, tx idle

   // ------------------------------------------------------------------
   // Counts
   // ------------------------------------------------------------------
   localparam logic [4:0] FAC_WORD_BITS     = 5'h10;  // 16 bits a codeword
   localparam logic [3:0] FAC_REPEAT_COUNT  = 4'ha;   // 10 codewords
   localparam logic [1:0] FAC_VALID_COUNT   = 2'h3;   // 3 matching words
   localparam logic [1:0] FAC_CLEAR_COUNT   = 2'h2;   // 2 differing words
   localparam logic [4:0] FAC_IDLE_ONES     = 5'h10;  // 16 ones
   localparam int         FAC_FIFO_DEPTH    = 4;

   // ------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------
   typedef enum logic [1:0]
   {
      FAC_ACT_IDLE   = 2'b00,
      FAC_ACT_A_TEN  = 2'b01,
      FAC_ACT_A_B    = 2'b10,
      FAC_ACT_A_CONT = 2'b11
   } fac_action_t;

   typedef enum logic [1:0]
   {
      FAC_TX_IDLE   = 2'b00,
      FAC_TX_SEND_A = 2'b01,
      FAC_TX_SEND_B = 2'b10
   } fac_tx_state_t;

   typedef enum logic [1:0]
   {
      FAC_MODE_E3     = 2'b00,
      FAC_MODE_M23    = 2'b01,
      FAC_MODE_CBIT   = 2'b10
   } fac_mode_t;

   // Host register port request
   typedef struct packed
   {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } fac_bus_req_t;

   // Overhead bit slot from the framer
   typedef struct packed
   {
      logic rx_bit;      // received overhead bit
      logic rx_strobe;   // rx_bit is valid this cycle
      logic tx_strobe;   // a transmit bit is taken this cycle
   } fac_slot_t;

endpackage : fac_pkg

// ==== hw/fac_ctrl.sv ====
// Far-end alarm codeword controller: transmitter, receiver, queue, registers
//
// Functional notes
// - Codeword is 16 bits: eight ones, zero, six payload, zero; ones end first.
// - In DS3 C-bit mode drive and monitor the alarm channel.
// - In E3 mode the receiver is always fed from the national bit.
// - In E3 mode transmit drives the national bit only when source select is 10.
// - In DS3 M23 framing the controller takes no part.
// - Idle transmitter sends ones; tx idle live high then, low while sending.
// - Select 00 idle, 01 A ten times, 10 A then B ten each, 11 A continuously.
// - Transmission starts only on select change from 00 to nonzero.
// - Actions 01 and 10 finish even when select is rewritten to 00.
// - Continuous mode sends at least 10 codewords before 00 ends it.
// - Receiver searches for a codeword at every bit position.
// - Codeword valid only after seen identical in three consecutive opportunities.
// - On validation raise codeword-seen live and push payload into queue.
// - Receive queue holds four entries.
// - Validated codeword while queue full is dropped; overflow sticky is set.
// - Codeword-seen live clears after a different codeword twice in a row.
// - Rising edge of rx reset bit resets receiver and empties queue.
// - Rx idle live sets after 16 ones; clears on a new validation.
// - Queue-empty live is high whenever the queue holds no entries.
// - Tx idle, codeword-seen and rx idle sticky bits set on rising edge of their live status; write one clears.
// - Interrupt while sticky bit, its enable and block enable are all set.
// - Nonempty sticky sets when queue-empty live falls.
// - Rx data shows six payload bits, bit 0 first; tx payload bit 0 first.
`timescale 1ns/1ps

module fac_ctrl
(
   input  wire logic             ref_clk_in,
   input  wire logic             rst_n_in,
   input  wire fac_pkg::fac_bus_req_t bus_in,
   output logic [7:0]            rdata_out,
   input  wire fac_pkg::fac_mode_t mode_in,
   input  wire logic [1:0]       national_bit_source_sel_in,
   input  wire logic             alarm_block_irq_en_in,
   input  wire fac_pkg::fac_slot_t slot_in,
   output logic                  tx_bit_out,
   output logic                  tx_drive_out,
   output logic                  irq_out
);
   import fac_pkg::*;
   // ------------------------------------------------------------------
   // Register decode
   // ------------------------------------------------------------------
   logic [1:0] tx_action_select;
   logic       rx_reset_request;
   logic [4:0] sticky;
   logic [4:0] irq_en;
   logic [5:0] tx_payload_first;
   logic [5:0] tx_payload_second;
   wire wr_ctrl   = bus_in.wr && (bus_in.addr == FAC_ADDR_CTRL);
   wire wr_sticky = bus_in.wr && (bus_in.addr == FAC_ADDR_STICKY);
   wire wr_irq    = bus_in.wr && (bus_in.addr == FAC_ADDR_IRQ_EN);
   wire wr_first  = bus_in.wr && (bus_in.addr == FAC_ADDR_TX_FIRST);
   wire wr_second = bus_in.wr && (bus_in.addr == FAC_ADDR_TX_SEC);
   wire rd_data   = bus_in.rd && (bus_in.addr == FAC_ADDR_RX_DATA);
   // Mode gating: M23 leaves the block inert
   wire mode_active = (mode_in != FAC_MODE_M23);
   wire rx_enable   = (mode_in == FAC_MODE_CBIT) ||
                      (mode_in == FAC_MODE_E3);
   wire tx_drive    = (mode_in == FAC_MODE_CBIT) ||
                      ((mode_in == FAC_MODE_E3) &&
                       (national_bit_source_sel_in == 2'b10));
   wire [1:0] next_sel = bus_in.wdata[1:0];
   wire       rx_reset_rise = wr_ctrl && !rx_reset_request &&
                              bus_in.wdata[FAC_CTRL_RX_RESET_BIT];
   // Control and configuration writes
   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_n_in)
      begin
         tx_action_select  <= 2'b00;
         rx_reset_request  <= 1'b0;
         irq_en            <= 5'h00;
         tx_payload_first  <= 6'h00;
         tx_payload_second <= 6'h00;
      end
      else
      begin
         if (wr_ctrl)
         begin
            tx_action_select <= next_sel;
            rx_reset_request <= bus_in.wdata[FAC_CTRL_RX_RESET_BIT];
         end
         if (wr_irq)
            irq_en <= bus_in.wdata[4:0];
         if (wr_first)
            tx_payload_first <= bus_in.wdata[5:0];
         if (wr_second)
            tx_payload_second <= bus_in.wdata[5:0];
      end
   end

   // ------------------------------------------------------------------
   // Transmitter
   // ------------------------------------------------------------------
   fac_tx_state_t tx_state;
   fac_action_t   tx_action;
   logic [3:0]    tx_bit_idx;
   logic [3:0]    tx_word_cnt;
   logic          start_req;
   // Start only on a 00 -> nonzero write; unchanged values do nothing
   wire start_edge = wr_ctrl && (tx_action_select == 2'b00) &&
                     (next_sel != 2'b00);
   wire sel_idle   = (tx_action_select == 2'b00);
   // Codeword image, ones end first: bits 0..7 ones, 8 zero,
   // 9..14 payload bit 0 first, 15 zero
   wire [5:0]  cur_payload = (tx_state == FAC_TX_SEND_B) ?
                             tx_payload_second : tx_payload_first;
   wire [15:0] tx_word = {1'b0, cur_payload, 1'b0, 8'hff};
   wire        word_end = slot_in.tx_strobe && (tx_bit_idx == 4'hf);
   wire        tenth    = (tx_word_cnt == FAC_REPEAT_COUNT - 4'h1);
   wire        cont_ok  = (tx_word_cnt == FAC_REPEAT_COUNT - 4'h1) ||
                          (tx_word_cnt == FAC_REPEAT_COUNT);
   // Word sequencing; a start is held until the next word boundary
   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_n_in || !mode_active)
      begin
         tx_state    <= FAC_TX_IDLE;
         tx_action   <= FAC_ACT_IDLE;
         tx_bit_idx  <= 4'h0;
         tx_word_cnt <= 4'h0;
         start_req   <= 1'b0;
      end
      else
      begin
         if (start_edge)
         begin
            start_req <= 1'b1;
            tx_action <= fac_action_t'(next_sel);
         end
         if (slot_in.tx_strobe)
            tx_bit_idx <= tx_bit_idx + 4'h1;
         unique case (tx_state)
            FAC_TX_IDLE:
               if (start_req && slot_in.tx_strobe &&
                   tx_bit_idx == 4'hf)
               begin
                  tx_state    <= FAC_TX_SEND_A;
                  tx_word_cnt <= 4'h0;
                  start_req   <= 1'b0;
               end
            FAC_TX_SEND_A:
               if (word_end)
               begin
                  if (!cont_ok)
                     tx_word_cnt <= tx_word_cnt + 4'h1;
                  if (tx_action == FAC_ACT_A_CONT)
                  begin
                     if (cont_ok && sel_idle)
                        tx_state <= FAC_TX_IDLE;
                  end
                  else if (tenth)
                  begin
                     tx_word_cnt <= 4'h0;
                     tx_state    <= (tx_action == FAC_ACT_A_B) ?
                                    FAC_TX_SEND_B : FAC_TX_IDLE;
                  end
               end
            FAC_TX_SEND_B:
               if (word_end)
               begin
                  tx_word_cnt <= tx_word_cnt + 4'h1;
                  if (tenth)
                     tx_state <= FAC_TX_IDLE;
               end
            default:
               tx_state <= FAC_TX_IDLE;
         endcase
      end
   end
   wire tx_idle_live = (tx_state == FAC_TX_IDLE);
   wire tx_bit_now   = tx_idle_live ? 1'b1 : tx_word[tx_bit_idx];
   // ------------------------------------------------------------------
   // Receiver
   // ------------------------------------------------------------------
   logic [15:0] rx_shift;
   logic [4:0]  rx_fill;
   logic [5:0]  cand;
   logic [1:0]  cand_cnt;
   logic [5:0]  valid_word;
   logic [1:0]  diff_cnt;
   logic        rx_seen_live;
   logic        rx_idle_live;
   logic [4:0]  ones_cnt;
   logic [3:0]  since_match;
   // Newest bit enters at the top, so the first bit sits at bit 0
   wire [15:0] next_shift = {slot_in.rx_bit, rx_shift[15:1]};
   wire        rx_take    = slot_in.rx_strobe && rx_enable;
   // Pattern: low byte ones, bit 8 zero, bit 15 zero
   wire        hit = rx_take && (rx_fill >= FAC_WORD_BITS - 5'h1) &&
                     (next_shift[7:0] == 8'hff) && !next_shift[8] &&
                     !next_shift[15];
   wire [5:0]  hit_word  = next_shift[14:9];
   // A hit 16 bits after the last is the next opportunity
   wire        in_step   = (since_match == 4'hf);
   wire        same      = hit && in_step && (hit_word == cand);
   wire        validate  = same && (cand_cnt == FAC_VALID_COUNT - 2'h1) &&
                           !(rx_seen_live && hit_word == valid_word);
   wire        other     = hit && in_step && rx_seen_live &&
                           (hit_word != valid_word);
   // Codeword search and debounce
   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_n_in || rx_reset_rise || !mode_active)
      begin
         rx_shift     <= 16'h0000;
         rx_fill      <= 5'h00;
         cand         <= 6'h00;
         cand_cnt     <= 2'h0;
         valid_word   <= 6'h00;
         diff_cnt     <= 2'h0;
         rx_seen_live <= 1'b0;
         rx_idle_live <= 1'b0;
         ones_cnt     <= 5'h00;
         since_match  <= 4'h0;
      end
      else if (rx_take)
      begin
         rx_shift <= next_shift;
         if (rx_fill < FAC_WORD_BITS)
            rx_fill <= rx_fill + 5'h01;
         since_match <= hit ? 4'h0 : since_match + 4'h1;
         if (slot_in.rx_bit && ones_cnt < FAC_IDLE_ONES)
            ones_cnt <= ones_cnt + 5'h01;
         else if (!slot_in.rx_bit)
            ones_cnt <= 5'h00;
         if (slot_in.rx_bit && ones_cnt == FAC_IDLE_ONES - 5'h01)
            rx_idle_live <= 1'b1;
         if (hit)
         begin
            if (same && cand_cnt != FAC_VALID_COUNT)
               cand_cnt <= cand_cnt + 2'h1;
            else if (!same)
            begin
               cand     <= hit_word;
               cand_cnt <= 2'h1;
            end
         end
         if (validate)
         begin
            rx_seen_live <= 1'b1;
            valid_word   <= hit_word;
            rx_idle_live <= 1'b0;
            diff_cnt     <= 2'h0;
         end
         else if (other)
         begin
            diff_cnt <= diff_cnt + 2'h1;
            if (diff_cnt == FAC_CLEAR_COUNT - 2'h1)
               rx_seen_live <= 1'b0;
         end
         else if (hit && in_step)
            diff_cnt <= 2'h0;
      end
   end

   // ------------------------------------------------------------------
   // Receive queue, four entries
   // ------------------------------------------------------------------
   logic [5:0] queue [FAC_FIFO_DEPTH];
   logic [1:0] q_wr;
   logic [1:0] q_rd;
   logic [2:0] q_cnt;
   wire q_full  = (q_cnt == 3'(FAC_FIFO_DEPTH));
   wire q_empty = (q_cnt == 3'h0);
   wire q_push  = validate && !q_full;
   wire q_pop   = rd_data && !q_empty;
   wire q_drop  = validate && q_full;
   // Pointers; a read and a push in one cycle keep the count
   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_n_in || rx_reset_rise || !mode_active)
      begin
         q_wr  <= 2'h0;
         q_rd  <= 2'h0;
         q_cnt <= 3'h0;
      end
      else
      begin
         if (q_push)
         begin
            queue[q_wr] <= hit_word;
            q_wr        <= q_wr + 2'h1;
         end
         if (q_pop)
            q_rd <= q_rd + 2'h1;
         if (q_push && !q_pop)
            q_cnt <= q_cnt + 3'h1;
         else if (q_pop && !q_push)
            q_cnt <= q_cnt - 3'h1;
      end
   end

   // ------------------------------------------------------------------
   // Sticky status and interrupt
   // ------------------------------------------------------------------
   wire [3:0] live = {q_empty, rx_idle_live, rx_seen_live, tx_idle_live};
   logic [3:0] live_d;
   // Rising edges; nonempty watches the falling edge of empty, overflow the drop
   wire [4:0] ev = {q_drop,
                    live_d[3] && !live[3],
                    live[2:0] & ~live_d[2:0]};
   wire [4:0] clr = wr_sticky ? bus_in.wdata[4:0] : 5'h00;
   // A set in the same cycle as its clear wins
   wire [4:0] next_sticky = (sticky & ~clr) | ev;
   wire       next_irq = alarm_block_irq_en_in &&
                         |(next_sticky & irq_en);
   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_n_in)
      begin
         sticky <= 5'h00;
         live_d <= FAC_LIVE_RST;   // Idle levels: no false edge
         irq_out <= 1'b0;
      end
      else
      begin
         sticky  <= next_sticky;
         live_d  <= live;
         irq_out <= next_irq;
      end
   end

   // ------------------------------------------------------------------
   // Read data and line outputs
   // ------------------------------------------------------------------
   logic [7:0] next_rdata;
   always_comb
   begin
      next_rdata = 8'h00;
      if (bus_in.rd)
      begin
         unique case (bus_in.addr)
            FAC_ADDR_CTRL:     next_rdata = {5'h00, rx_reset_request,
                                             tx_action_select};
            FAC_ADDR_LIVE:     next_rdata = {4'h0, live};
            FAC_ADDR_STICKY:   next_rdata = {3'h0, sticky};
            FAC_ADDR_IRQ_EN:   next_rdata = {3'h0, irq_en};
            FAC_ADDR_TX_FIRST: next_rdata = {2'h0, tx_payload_first};
            FAC_ADDR_TX_SEC:   next_rdata = {2'h0, tx_payload_second};
            FAC_ADDR_RX_DATA:  next_rdata = {2'h0, queue[q_rd]};
            default:           next_rdata = 8'h00;
         endcase
      end
   end
   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_n_in)
      begin
         rdata_out    <= FAC_RST_REG;
         tx_bit_out   <= 1'b1;
         tx_drive_out <= 1'b0;
      end
      else
      begin
         rdata_out    <= next_rdata;
         tx_bit_out   <= tx_bit_now;
         tx_drive_out <= tx_drive && mode_active;
      end
   end

endmodule // fac_ctrl

// ==== test/fac_ctrl_sva.sv ====
// Checker: port-level properties of the alarm codeword controller
`timescale 1ns/1ps

module fac_ctrl_sva
(
   input wire logic                  ref_clk_in,
   input wire logic                  rst_n_in,
   input wire fac_pkg::fac_bus_req_t bus_in,
   input wire logic [7:0]            rdata_out,
   input wire fac_pkg::fac_mode_t    mode_in,
   input wire logic [1:0]            national_bit_source_sel_in,
   input wire logic                  alarm_block_irq_en_in,
   input wire fac_pkg::fac_slot_t    slot_in,
   input wire logic                  tx_bit_out,
   input wire logic                  tx_drive_out,
   input wire logic                  irq_out
);
   import fac_pkg::*;

   // ----------------
   // Helpers
   // ----------------
   default clocking cb @(posedge ref_clk_in);
   endclocking
   // Outputs follow reset one edge late, so checks wait one more edge
   logic rst_seen;
   always_ff @(posedge ref_clk_in)
      rst_seen <= rst_n_in;
   default disable iff (!rst_n_in || !rst_seen);

   // Decoded host accesses and E3 source select
   wire rd_live = bus_in.rd && bus_in.addr == FAC_ADDR_LIVE;
   wire rd_data = bus_in.rd && bus_in.addr == FAC_ADDR_RX_DATA;
   wire irq_off = bus_in.wr && bus_in.addr == FAC_ADDR_IRQ_EN
                  && bus_in.wdata == 8'h00;
   wire e3_own  = national_bit_source_sel_in == 2'b10;

   // ----------------
   // Line side
   // ----------------
   chk_m23_no_drive: assert property
      ((mode_in == FAC_MODE_M23)[*2] |-> !tx_drive_out)
      else $error("tx drive seen in m23 framing");
   chk_e3_drive_off: assert property
      ((mode_in == FAC_MODE_E3 && !e3_own)[*2] |-> !tx_drive_out)
      else $error("tx drive seen in e3 without source select");
   chk_e3_drive_on: assert property
      ((mode_in == FAC_MODE_E3 && e3_own)[*2] |-> tx_drive_out)
      else $error("no tx drive in e3 with source select");
   chk_cbit_drive_on: assert property
      ((mode_in == FAC_MODE_CBIT)[*2] |-> tx_drive_out)
      else $error("no tx drive in c-bit mode");
   // Bit moves two edges after the slot that consumed it
   chk_tx_bit_hold: assert property
      (!slot_in.tx_strobe ##1 1'b1 |=> $stable(tx_bit_out))
      else $error("tx bit changed without a slot");

   // ----------------
   // Host side
   // ----------------
   chk_rx_data_width: assert property
      (rd_data |=> rdata_out[7:6] == 2'h0)
      else $error("rx data upper bits not zero");
   chk_live_width: assert property
      (rd_live |=> rdata_out[7:4] == 4'h0)
      else $error("live status upper bits not zero");
   chk_irq_global_off: assert property
      ((!alarm_block_irq_en_in)[*2] |-> !irq_out)
      else $error("irq with block enable low");
   chk_irq_mask_off: assert property
      (irq_off |-> ##2 !irq_out)
      else $error("irq stays after enables cleared");
   chk_irq_rise_cause: assert property
      ($rose(irq_out) |-> $past(alarm_block_irq_en_in))
      else $error("irq rose without block enable");

   // Main scenarios reached
   cover property ($rose(irq_out));
   cover property (tx_drive_out && !tx_bit_out);
   cover property (rd_data);
endmodule // fac_ctrl_sva

// ==== test/fac_framer_model.sv ====
// Model: framer overhead slot timing with the alarm channel looped back
`timescale 1ns/1ps

module fac_framer_model
(
   input  wire logic         ref_clk_in,
   input  wire logic         rst_n_in,
   input  wire logic         tx_bit_in,
   input  wire logic         tx_drive_in,
   output fac_pkg::fac_slot_t slot_out,
   output logic [15:0]       zeros_out
);
   import fac_pkg::*;

   logic [1:0] phase;
   wire        slot_now = phase == 2'h3;

   // One slot every four clocks keeps strobes well apart
   always_ff @(posedge ref_clk_in)
   begin
      phase <= rst_n_in ? phase + 2'h1 : 2'h0;
   end

   // Undriven channel reads as idle ones, so E3 without source is quiet
   // One driver for the whole slot word
   assign slot_out = {(tx_drive_in ? tx_bit_in : 1'b1),
                      slot_now, slot_now};

   // Zeros sent tell the bench how many codewords went out
   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_n_in)
         zeros_out <= 16'h0000;
      else if (slot_now && tx_drive_in && !tx_bit_in)
         zeros_out <= zeros_out + 16'h0001;
   end
endmodule // fac_framer_model

// ==== test/test_fac_ctrl.sv ====
// Testbench: register-driven scenarios for the alarm codeword controller
`timescale 1ns/1ps

module test_fac_ctrl;
   import fac_pkg::*;

   logic         ref_clk;
   logic         rst_n;
   fac_bus_req_t bus;
   logic [7:0]   rdata;
   fac_mode_t    mode;
   logic [1:0]   sel;
   logic         glob_en;
   fac_slot_t    slot;
   logic         tx_bit;
   logic         tx_drive;
   logic         irq;
   logic [15:0]  zeros;
   logic [15:0]  z;
   int           mismatches;
   int           samples_checked;
   localparam logic [7:0] RW_REGS [4] = '{FAC_ADDR_CTRL, FAC_ADDR_IRQ_EN,
      FAC_ADDR_TX_FIRST, FAC_ADDR_TX_SEC};

   fac_ctrl uut (.ref_clk_in(ref_clk), .rst_n_in(rst_n), .bus_in(bus),
      .rdata_out(rdata), .mode_in(mode), .national_bit_source_sel_in(sel),
      .alarm_block_irq_en_in(glob_en), .slot_in(slot),
      .tx_bit_out(tx_bit), .tx_drive_out(tx_drive), .irq_out(irq));
   fac_framer_model framer (.ref_clk_in(ref_clk), .rst_n_in(rst_n),
      .tx_bit_in(tx_bit), .tx_drive_in(tx_drive), .slot_out(slot),
      .zeros_out(zeros));

   // --------------------
   // Bus tasks, each begins and ends on a rising edge
   // --------------------
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      begin
         bus <= '{a, d, 1'b1, 1'b0};
         @(posedge ref_clk);
         bus <= '0;
         @(posedge ref_clk);
      end
   endtask

   // Data is taken in the one cycle it stands
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      begin
         bus <= '{a, 8'h00, 1'b0, 1'b1};
         @(posedge ref_clk);
         bus <= '0;
         #1 d = rdata;
         @(posedge ref_clk);
      end
   endtask

   task automatic cmp(input string what, input logic [7:0] e,
                      input logic [7:0] g);
      begin
         samples_checked++;
         if (g !== e)
         begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, e, g);
         end
      end
   endtask

   task automatic rc(input logic [7:0] a, input logic [7:0] m,
                     input logic [7:0] e);
      logic [7:0] d;
      begin
         rd(a, d);
         cmp($sformatf("register %h", a), e, d & m);
      end
   endtask

   // Polls tx idle; a stuck transmitter ends the run
   task automatic wait_tx(input logic v);
      logic [7:0] d;
      int         n;
      begin
         for (n = 0; n < 1000; n++)
         begin
            rd(FAC_ADDR_LIVE, d);
            if (d[FAC_ST_TX_IDLE] === v)
               break;
         end
         if (n == 1000)
         begin
            mismatches++;
            summarize();
         end
      end
   endtask

   task automatic go(input logic [7:0] act, input logic stop);
      begin
         z = zeros;
         wr(FAC_ADDR_CTRL, 8'h00);
         wr(FAC_ADDR_CTRL, act);
         wait_tx(1'b0);
         if (stop)
            wr(FAC_ADDR_CTRL, 8'h00);
         wait_tx(1'b1);
      end
   endtask

   task automatic summarize;
      begin
         $display("checks %0d mismatches %0d", samples_checked, mismatches);
         if (mismatches == 0 && samples_checked > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask

   // --------------------
   // Clock and scenarios
   // --------------------
   initial
   begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   initial
   begin
      mismatches = 0;
      samples_checked = 0;
      bus = '0;
      mode = FAC_MODE_CBIT;
      sel = 2'b00;
      glob_en = 1'b1;
      rst_n = 1'b0;
      repeat (16) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      for (int i = 0; i < 4; i++)
         rc(RW_REGS[i], 8'hff, 8'h00);
      rc(FAC_ADDR_LIVE, 8'hff, 8'h09);
      repeat (80) @(posedge ref_clk);
      rc(FAC_ADDR_LIVE, 8'hff, 8'h0d);
      wr(FAC_ADDR_LIVE, 8'h00);
      wr(8'h67, 8'hff);
      rc(8'h67, 8'hff, 8'h00);
      rc(FAC_ADDR_LIVE, 8'hff, 8'h0d);
      wr(FAC_ADDR_TX_FIRST, 8'hed);
      rc(FAC_ADDR_TX_FIRST, 8'hff, 8'h2d);
      wr(FAC_ADDR_TX_SEC, 8'h12);
      wr(FAC_ADDR_STICKY, 8'h1f);
      // Ten A words survive an early idle write
      go(8'h01, 1'b1);
      cmp("zeros sent", 8'h28, 8'(zeros - z));
      repeat (80) @(posedge ref_clk);
      rc(FAC_ADDR_RX_DATA, 8'hff, 8'h2d);
      rc(FAC_ADDR_LIVE, 8'h09, 8'h09);
      rc(FAC_ADDR_STICKY, 8'hff, 8'h0f);
      wr(FAC_ADDR_STICKY, 8'h01);
      rc(FAC_ADDR_STICKY, 8'hff, 8'h0e);
      // Five new words into a four-entry queue; A repeated is not new
      for (int i = 0; i < 3; i++)
      begin
         go(8'h02, 1'b0);
         if (i == 0)
            cmp("zeros sent", 8'h64, 8'(zeros - z));
      end
      z = zeros;
      wr(FAC_ADDR_CTRL, 8'h02);
      repeat (300) @(posedge ref_clk);
      cmp("zeros sent", 8'h00, 8'(zeros - z));
      wr(FAC_ADDR_IRQ_EN, 8'h10);
      repeat (3) @(posedge ref_clk);
      cmp("irq", 8'h01, {7'h00, irq});
      glob_en <= 1'b0;
      repeat (3) @(posedge ref_clk);
      cmp("irq", 8'h00, {7'h00, irq});
      glob_en <= 1'b1;
      repeat (3) @(posedge ref_clk);
      cmp("irq", 8'h01, {7'h00, irq});
      wr(FAC_ADDR_STICKY, 8'h10);
      repeat (3) @(posedge ref_clk);
      cmp("irq", 8'h00, {7'h00, irq});
      wr(FAC_ADDR_IRQ_EN, 8'h00);
      rc(FAC_ADDR_RX_DATA, 8'hff, 8'h12);
      rc(FAC_ADDR_RX_DATA, 8'hff, 8'h2d);
      wr(FAC_ADDR_CTRL, 8'h04);
      rc(FAC_ADDR_LIVE, 8'h08, 8'h08);
      // Continuous A stopped at once still sends ten
      go(8'h03, 1'b1);
      cmp("ten words", 8'h01, {7'h00, (zeros - z) >= 16'h0028});
      rc(FAC_ADDR_RX_DATA, 8'hff, 8'h2d);
      mode <= FAC_MODE_E3;
      repeat (3) @(posedge ref_clk);
      cmp("tx drive", 8'h00, {7'h00, tx_drive});
      sel <= 2'b10;
      wr(FAC_ADDR_TX_FIRST, 8'h33);
      go(8'h01, 1'b0);
      cmp("tx drive", 8'h01, {7'h00, tx_drive});
      rc(FAC_ADDR_RX_DATA, 8'hff, 8'h33);
      mode <= FAC_MODE_M23;
      z = zeros;
      wr(FAC_ADDR_CTRL, 8'h00);
      wr(FAC_ADDR_CTRL, 8'h01);
      repeat (300) @(posedge ref_clk);
      cmp("zeros sent", 8'h00, 8'(zeros - z));
      cmp("tx drive", 8'h00, {7'h00, tx_drive});
      summarize();
   end
endmodule // test_fac_ctrl

bind fac_ctrl fac_ctrl_sva chk_i (.ref_clk_in(ref_clk_in),
   .rst_n_in(rst_n_in), .bus_in(bus_in), .rdata_out(rdata_out),
   .mode_in(mode_in),
   .national_bit_source_sel_in(national_bit_source_sel_in),
   .alarm_block_irq_en_in(alarm_block_irq_en_in), .slot_in(slot_in),
   .tx_bit_out(tx_bit_out), .tx_drive_out(tx_drive_out),
   .irq_out(irq_out));
